// ### hw/nand_read_pkg.sv
package nand_read_pkg;

  // ****************************************************************
  // Opcodes, buffer geometry and link timing.
  // ****************************************************************

  // Read opcodes served by this path.
  localparam logic [7:0] OP_QO4 = 8'h6C;
  localparam logic [7:0] OP_DIO = 8'hBB;
  localparam logic [7:0] OP_DIO4 = 8'hBC;
  localparam logic [7:0] OP_QIO = 8'hEB;
  localparam logic [7:0] OP_QIO4 = 8'hEC;

  // Data buffer is one page with its spare area.
  localparam int BUF_BYTES = 2112;
  localparam int ADDR_W = 12;
  localparam logic [15:0] LAST_COL = 16'h083F;
  localparam logic [15:0] FIRST_COL = 16'h0000;
  localparam logic [15:0] COL_STEP = 16'h0001;

  // Clocks per phase; address phases include the dummy clocks.
  localparam logic [5:0] CMD_CLKS = 6'h08;
  localparam logic [5:0] AD_QO4 = 6'h28;
  localparam logic [5:0] AD_DIO_B1 = 6'h0C;
  localparam logic [5:0] AD_DIO_B0 = 6'h10;
  localparam logic [5:0] AD_DIO4 = 6'h14;
  localparam logic [5:0] AD_QIO = 6'h08;
  localparam logic [5:0] AD_QIO4 = 6'h0E;
  localparam logic [5:0] COL_C1 = 6'h10;
  localparam logic [5:0] COL_C2 = 6'h08;
  localparam logic [5:0] COL_C4 = 6'h04;
  localparam logic [2:0] LN1 = 3'h1;
  localparam logic [2:0] LN2 = 3'h2;
  localparam logic [2:0] LN4 = 3'h4;
  localparam logic [3:0] BYTE_C2 = 4'h4;
  localparam logic [3:0] BYTE_C4 = 4'h2;

  // Host side timing at the 40 MHz system clock.
  localparam int SYS_NS = 25;
  localparam int HALF_NS = 100;
  localparam int DESEL_NS = 100;
  localparam logic [3:0] HALF_CYC = 4'(HALF_NS / SYS_NS);
  localparam logic [3:0] DESEL_CYC = 4'((DESEL_NS + SYS_NS - 1) / SYS_NS);
  localparam int FIFO_DEPTH = 32;

  typedef enum {D_CMD, D_ADDR, D_DATA, D_IDLE} dev_state_t;
  typedef enum {H_IDLE, H_CMD, H_ADDR, H_DATA, H_DESEL} host_state_t;

  // Lines that carry address and dummy bits.
  function automatic logic [2:0] lanes_in(input logic [7:0] op);
    case (op)
      OP_DIO, OP_DIO4: lanes_in = LN2;
      OP_QIO, OP_QIO4: lanes_in = LN4;
      default: lanes_in = LN1;
    endcase
  endfunction : lanes_in

  // Lines that carry read data.
  function automatic logic [2:0] lanes_out(input logic [7:0] op);
    lanes_out = (op == OP_DIO || op == OP_DIO4) ? LN2 : LN4;
  endfunction : lanes_out

  function automatic logic known(input logic [7:0] op);
    known = op inside {OP_QO4, OP_DIO, OP_DIO4, OP_QIO, OP_QIO4};
  endfunction : known

  function automatic logic is_quad(input logic [7:0] op);
    is_quad = op inside {OP_QO4, OP_QIO, OP_QIO4};
  endfunction : is_quad

  function automatic logic [5:0] addr_clks(input logic [7:0] op, input logic buf_mode);
    case (op)
      OP_DIO: addr_clks = buf_mode ? AD_DIO_B1 : AD_DIO_B0;
      OP_DIO4: addr_clks = AD_DIO4;
      OP_QIO: addr_clks = AD_QIO;
      OP_QIO4: addr_clks = AD_QIO4;
      default: addr_clks = AD_QO4;
    endcase
  endfunction : addr_clks

  function automatic logic [5:0] col_clks(input logic [7:0] op);
    case (lanes_in(op))
      LN2: col_clks = COL_C2;
      LN4: col_clks = COL_C4;
      default: col_clks = COL_C1;
    endcase
  endfunction : col_clks

  function automatic logic [3:0] byte_clks(input logic [7:0] op);
    byte_clks = (lanes_out(op) == LN2) ? BYTE_C2 : BYTE_C4;
  endfunction : byte_clks

endpackage : nand_read_pkg

// ### hw/nand_spi_if.sv
`timescale 1ns/10ps
`default_nettype none
interface nand_spi_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // Wire level per line: device, then host, else the pull-up holds it high.
  assign io = (dev_io_oe & dev_io_o) | (~dev_io_oe & host_io_oe & host_io_o)
              | (~dev_io_oe & ~host_io_oe);

  modport dev (input sclk, input cs_n, input io, output dev_io_o, output dev_io_oe);
  modport host (output sclk, output cs_n, output host_io_o, output host_io_oe, input io);
endinterface : nand_spi_if
`default_nettype wire

// ### hw/nand_read_dev.sv
// Function
// - 6Ch reads out on four lines
// - BBh address, dummy, data on two lines
// - BCh is long-form dual I/O read
// - EBh address, dummy, data on four lines
// - ECh is long-form quad I/O read
// - Buffer mode starts at given column
// - Buffer mode stops, lines float after last
// - Continuous mode starts at byte zero
// - Continuous mode wraps into next page
// - Write-protect enable rejects quad opcodes
// - MSB first, data changes on falling edge
// - Select low starts, high ends command
`timescale 1ns/10ps
`default_nettype none
module nand_read_dev (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic wr_en_i,
  input wire logic [11:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic buf_mode_i,
  input wire logic wp_enable_i,
  output logic page_next_o,
  nand_spi_if.dev link
);

  // ****************************************************************
  // Data buffer, loaded from the system side.
  // ****************************************************************

  logic [7:0] mem [nand_read_pkg::BUF_BYTES];

  // Written on the system clock and read on the link clock; the user
  // must not load the buffer while a read frame is running.
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // ****************************************************************
  // Mode levels brought onto the link clock.
  // ****************************************************************

  logic buf_s1;
  logic buf_s2;
  logic wp_s1;
  logic wp_s2;

  // The link clock only runs in frames, so these levels must be stable
  // over the first six link edges of a frame; that frame's command phase then uses them.
  always_ff @(posedge link.sclk or negedge nrst_i) begin
    if (!nrst_i) begin
      buf_s1 <= 1'b1;
      buf_s2 <= 1'b1;
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
    end else begin
      buf_s1 <= buf_mode_i;
      buf_s2 <= buf_s1;
      wp_s1 <= wp_enable_i;
      wp_s2 <= wp_s1;
    end
  end

  // ****************************************************************
  // Frame state on the rising link edge.
  // ****************************************************************

  nand_read_pkg::dev_state_t state;
  nand_read_pkg::dev_state_t next_state;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [7:0] op;
  logic [7:0] next_op;
  logic [15:0] col;
  logic [15:0] next_col;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [3:0] bcnt;
  logic [3:0] next_bcnt;
  logic bufm;
  logic next_bufm;
  logic page_adv;
  logic [7:0] cmd_word;
  logic [15:0] start;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_op = op;
    next_col = col;
    next_addr = addr;
    next_sh = sh;
    next_bcnt = bcnt;
    next_bufm = bufm;
    page_adv = 1'b0;
    cmd_word = {op[6:0], link.io[0]};
    start = nand_read_pkg::FIRST_COL;
    case (state)
      nand_read_pkg::D_CMD: begin
        next_op = cmd_word;
        next_cnt = 6'(cnt + 6'h01);
        next_bufm = buf_s2;
        if (next_cnt == nand_read_pkg::CMD_CLKS) begin
          next_cnt = 6'h00;
          next_state = nand_read_pkg::D_ADDR;
          if (!nand_read_pkg::known(cmd_word) || (wp_s2 && nand_read_pkg::is_quad(cmd_word))) begin
            next_state = nand_read_pkg::D_IDLE;
          end
        end
      end
      nand_read_pkg::D_ADDR: begin
        next_cnt = 6'(cnt + 6'h01);
        if (cnt < nand_read_pkg::col_clks(op)) begin
          case (nand_read_pkg::lanes_in(op))
            nand_read_pkg::LN2: next_col = {col[13:0], link.io[1:0]};
            nand_read_pkg::LN4: next_col = {col[11:0], link.io[3:0]};
            default: next_col = {col[14:0], link.io[0]};
          endcase
        end
        if (next_cnt == nand_read_pkg::addr_clks(op, bufm)) begin
          start = bufm ? next_col : nand_read_pkg::FIRST_COL;
          next_addr = start;
          next_bcnt = 4'h0;
          next_sh = mem[start[nand_read_pkg::ADDR_W-1:0]];
          next_state = nand_read_pkg::D_DATA;
          if (start > nand_read_pkg::LAST_COL) begin
            next_state = nand_read_pkg::D_IDLE;
            // A column past the buffer reads beyond the array, so keep the shifter clean.
            next_sh = 8'h00;
          end
        end
      end
      nand_read_pkg::D_DATA: begin
        next_bcnt = 4'(bcnt + 4'h1);
        if (nand_read_pkg::lanes_out(op) == nand_read_pkg::LN2) begin
          next_sh = {sh[5:0], 2'b00};
        end else begin
          next_sh = {sh[3:0], 4'h0};
        end
        if (next_bcnt == nand_read_pkg::byte_clks(op)) begin
          next_bcnt = 4'h0;
          next_addr = 16'(addr + nand_read_pkg::COL_STEP);
          if (addr == nand_read_pkg::LAST_COL) begin
            next_addr = nand_read_pkg::FIRST_COL;
            page_adv = !bufm;
            if (bufm) begin
              next_state = nand_read_pkg::D_IDLE;
            end
          end
          next_sh = mem[next_addr[nand_read_pkg::ADDR_W-1:0]];
        end
      end
      default: next_state = nand_read_pkg::D_IDLE;
    endcase
  end

  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      state <= nand_read_pkg::D_CMD;
      cnt <= 6'h00;
      op <= 8'h00;
      col <= 16'h0000;
      addr <= 16'h0000;
      sh <= 8'h00;
      bcnt <= 4'h0;
      bufm <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      op <= next_op;
      col <= next_col;
      addr <= next_addr;
      sh <= next_sh;
      bcnt <= next_bcnt;
      bufm <= next_bufm;
    end
  end

  // ****************************************************************
  // Output drivers on the falling link edge.
  // ****************************************************************

  logic [3:0] io_out;
  logic [3:0] next_io_out;
  logic [3:0] io_oe;
  logic [3:0] next_io_oe;

  always_comb begin
    next_io_out = sh[7:4];
    next_io_oe = 4'h0;
    if (nand_read_pkg::lanes_out(op) == nand_read_pkg::LN2) begin
      next_io_out = {2'b00, sh[7:6]};
    end
    if (state == nand_read_pkg::D_DATA) begin
      next_io_oe = (nand_read_pkg::lanes_out(op) == nand_read_pkg::LN2) ? 4'h3 : 4'hF;
    end
  end

  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else begin
      io_out <= next_io_out;
      io_oe <= next_io_oe;
    end
  end

  assign link.dev_io_o = io_out;
  assign link.dev_io_oe = io_oe;

  // ****************************************************************
  // Page advance event carried to the system clock.
  // ****************************************************************

  logic page_tgl;
  logic next_page_tgl;
  logic pg_s1;
  logic pg_s2;
  logic pg_s3;
  logic next_page_next;

  // Kept out of the frame reset so a select edge cannot fake an event.
  always_comb begin
    next_page_tgl = page_tgl ^ page_adv;
    next_page_next = pg_s2 ^ pg_s3;
  end

  always_ff @(posedge link.sclk or negedge nrst_i) begin
    if (!nrst_i) begin
      page_tgl <= 1'b0;
    end else begin
      page_tgl <= next_page_tgl;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pg_s1 <= 1'b0;
      pg_s2 <= 1'b0;
      pg_s3 <= 1'b0;
      page_next_o <= 1'b0;
    end else begin
      pg_s1 <= page_tgl;
      pg_s2 <= pg_s1;
      pg_s3 <= pg_s2;
      page_next_o <= next_page_next;
    end
  end

endmodule : nand_read_dev
`default_nettype wire

// ### hw/nand_read_host.sv
`timescale 1ns/10ps
`default_nettype none
module nand_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wp;
  logic [PW:0] rp;
  logic [PW:0] next_wp;
  logic [PW:0] next_rp;

  // Extra pointer bit tells full from empty.
  always_comb begin
    in_ready_o = (wp[PW] == rp[PW]) || (wp[PW-1:0] != rp[PW-1:0]);
    out_valid_o = (wp != rp);
    next_wp = (in_valid_i && in_ready_o) ? (PW+1)'(wp + 1'b1) : wp;
    next_rp = (out_valid_o && out_ready_i) ? (PW+1)'(rp + 1'b1) : rp;
    out_data_o = mem[rp[PW-1:0]];
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (in_valid_i && in_ready_o) begin
      mem[wp[PW-1:0]] <= in_data_i;
    end
  end
endmodule : nand_byte_fifo

module nand_read_host (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [7:0] cmd_opcode_i,
  input wire logic [15:0] cmd_col_i,
  input wire logic cmd_buf_mode_i,
  input wire logic [15:0] cmd_len_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [7:0] rd_data_o,
  nand_spi_if.host link
);

  // ****************************************************************
  // Link sequencer; the link clock is divided from the system clock.
  // ****************************************************************

  nand_read_pkg::host_state_t st;
  nand_read_pkg::host_state_t next_st;
  logic [3:0] div;
  logic [3:0] next_div;
  logic sclk;
  logic next_sclk;
  logic cs_n;
  logic next_cs_n;
  logic [7:0] op;
  logic [7:0] next_op;
  logic bufm;
  logic next_bufm;
  logic [23:0] tx;
  logic [23:0] next_tx;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [15:0] left;
  logic [15:0] next_left;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic [3:0] io_out;
  logic [3:0] next_io_out;
  logic [3:0] io_oe;
  logic [3:0] next_io_oe;
  logic [3:0] io_s1;
  logic [3:0] io_s2;
  logic tick;
  logic rise;
  logic fall;
  logic push;
  logic fifo_ready;

  always_comb begin
    next_st = st;
    next_div = div;
    next_sclk = sclk;
    next_cs_n = cs_n;
    next_op = op;
    next_bufm = bufm;
    next_tx = tx;
    next_cnt = cnt;
    next_left = left;
    next_rx = rx;
    next_io_out = io_out;
    next_io_oe = io_oe;
    push = 1'b0;
    cmd_ready_o = (st == nand_read_pkg::H_IDLE);
    // A full FIFO freezes the link clock, so no byte is ever dropped.
    tick = (div == nand_read_pkg::HALF_CYC - 4'h1) &&
           !(st == nand_read_pkg::H_DATA && !fifo_ready);
    rise = tick && !sclk && st != nand_read_pkg::H_IDLE && st != nand_read_pkg::H_DESEL;
    fall = tick && sclk;
    if (st != nand_read_pkg::H_IDLE) begin
      next_div = tick ? 4'h0 : 4'(div + 4'h1);
      if (tick && st != nand_read_pkg::H_DESEL) begin
        next_sclk = !sclk;
      end
    end
    case (st)
      nand_read_pkg::H_IDLE: begin
        next_div = 4'h0;
        if (cmd_valid_i) begin
          next_cs_n = 1'b0;
          next_op = cmd_opcode_i;
          next_bufm = cmd_buf_mode_i;
          next_tx = {cmd_opcode_i, cmd_col_i};
          next_left = (cmd_len_i == 16'h0000) ? 16'h0001 : cmd_len_i;
          next_cnt = 6'h00;
          next_io_out = {3'b000, cmd_opcode_i[7]};
          next_io_oe = 4'h1;
          next_st = nand_read_pkg::H_CMD;
        end
      end
      nand_read_pkg::H_CMD: begin
        if (rise) begin
          next_tx = {tx[22:0], 1'b0};
          next_cnt = 6'(cnt + 6'h01);
          if (next_cnt == nand_read_pkg::CMD_CLKS) begin
            next_cnt = 6'h00;
            next_st = nand_read_pkg::H_ADDR;
          end
        end
        if (fall) begin
          next_io_out = {3'b000, tx[23]};
        end
      end
      nand_read_pkg::H_ADDR: begin
        if (fall) begin
          case (nand_read_pkg::lanes_in(op))
            nand_read_pkg::LN2: begin
              next_io_out = {2'b00, tx[23:22]};
              next_io_oe = 4'h3;
            end
            nand_read_pkg::LN4: begin
              next_io_out = tx[23:20];
              next_io_oe = 4'hF;
            end
            default: begin
              next_io_out = {3'b000, tx[23]};
              next_io_oe = 4'h1;
            end
          endcase
        end
        if (rise) begin
          next_tx = tx << nand_read_pkg::lanes_in(op);
          next_cnt = 6'(cnt + 6'h01);
          if (next_cnt == nand_read_pkg::addr_clks(op, bufm)) begin
            next_cnt = 6'h00;
            next_st = nand_read_pkg::H_DATA;
          end
        end
      end
      nand_read_pkg::H_DATA: begin
        if (fall) begin
          next_io_oe = 4'h0;
        end
        if (rise) begin
          if (nand_read_pkg::lanes_out(op) == nand_read_pkg::LN2) begin
            next_rx = {rx[5:0], io_s2[1:0]};
          end else begin
            next_rx = {rx[3:0], io_s2};
          end
          next_cnt = 6'(cnt + 6'h01);
          if (next_cnt[3:0] == nand_read_pkg::byte_clks(op)) begin
            next_cnt = 6'h00;
            push = 1'b1;
            next_left = 16'(left - 16'h0001);
            if (left == 16'h0001) begin
              next_st = nand_read_pkg::H_DESEL;
              next_div = 4'h0;
            end
          end
        end
      end
      nand_read_pkg::H_DESEL: begin
        next_cs_n = 1'b1;
        next_sclk = 1'b0;
        // The half-period tick would wrap div at three, so the gap counts on its own.
        next_div = 4'(div + 4'h1);
        next_io_oe = 4'h0;
        if (div == nand_read_pkg::DESEL_CYC) begin
          next_st = nand_read_pkg::H_IDLE;
        end
      end
      default: next_st = nand_read_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= nand_read_pkg::H_IDLE;
      div <= 4'h0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      op <= 8'h00;
      bufm <= 1'b1;
      tx <= 24'h000000;
      cnt <= 6'h00;
      left <= 16'h0000;
      rx <= 8'h00;
      io_out <= 4'h0;
      io_oe <= 4'h0;
      io_s1 <= 4'hF;
      io_s2 <= 4'hF;
    end else begin
      st <= next_st;
      div <= next_div;
      sclk <= next_sclk;
      cs_n <= next_cs_n;
      op <= next_op;
      bufm <= next_bufm;
      tx <= next_tx;
      cnt <= next_cnt;
      left <= next_left;
      rx <= next_rx;
      io_out <= next_io_out;
      io_oe <= next_io_oe;
      io_s1 <= link.io;
      io_s2 <= io_s1;
    end
  end

  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.host_io_o = io_out;
  assign link.host_io_oe = io_oe;

  // ****************************************************************
  // Read data buffer toward the user.
  // ****************************************************************

  nand_byte_fifo #(
    .WIDTH(8),
    .DEPTH(nand_read_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(next_rx),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o)
  );

endmodule : nand_read_host
`default_nettype wire

// ### test/nand_multi_io_fast_read_chk.sv
`timescale 1ns/10ps
`default_nettype none
module nand_multi_io_fast_read_chk (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  // ****
  // Link edge count.
  // ****
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic [7:0] rises;
  logic [7:0] next_rises;
  logic sclk_q;
  // Saturates so a long stream cannot wrap back below the address length.
  always_comb begin
    next_rises = rises;
    if (cs_n)
      next_rises = 8'h00;
    else if (sclk && !sclk_q && rises != 8'hFF)
      next_rises = rises + 8'h01;
  end
  // Registers the count and the previous link clock.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rises <= 8'h00;
      sclk_q <= 1'h0;
    end else begin
      rises <= next_rises;
      sclk_q <= sclk;
    end
  end
  // ****
  // Link checks.
  // ****
  // clock idles deselected.
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock high while deselected");
  a_dev_quiet: assert property (cs_n |-> dev_io_oe == 4'h0)
    else $error("device drives while deselected");
  a_no_clash: assert property ((dev_io_oe & host_io_oe) == 4'h0)
    else $error("host and device drive one line");
  a_lane_set: assert property (dev_io_oe inside {4'h0, 4'h3, 4'hF})
    else $error("device drives an odd set of lines");
  a_after_addr: assert property (|dev_io_oe |-> rises >= 8'h10)
    else $error("device drives before the address phase ends");
  a_turn_on: assert property ($rose(|dev_io_oe) |-> $fell(sclk))
    else $error("device output enabled off a falling edge");
  a_data_fall: assert property (!cs_n && $past(!cs_n) && $changed(dev_io_o) |-> $fell(sclk))
    else $error("device data changed off a falling edge");
  a_desel_gap: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("deselect shorter than four cycles");
endmodule : nand_multi_io_fast_read_chk
`default_nettype wire

// ### test/nand_multi_io_fast_read_tb.sv
`timescale 1ns/10ps
`default_nettype none
module nand_multi_io_fast_read_tb;
  // ****
  // Signals and ends.
  // ****
  logic sys_clk_i;
  logic nrst_i;
  logic wr_en_i;
  logic [11:0] wr_addr_i;
  logic [7:0] wr_data_i;
  logic buf_mode_i;
  logic wp_enable_i;
  logic page_next_o;
  logic cmd_valid_i;
  logic cmd_ready_o;
  logic [7:0] cmd_opcode_i;
  logic [15:0] cmd_col_i;
  logic cmd_buf_mode_i;
  logic [15:0] cmd_len_i;
  logic rd_valid_o;
  logic rd_ready_i;
  logic [7:0] rd_data_o;
  int errors;
  int cmp_count;
  int pages;
  typedef struct packed {
    logic [7:0] op;
    logic [15:0] col;
    logic bm;
    logic wp;
    logic [7:0] n;
  } row_t;
  // Rows are grouped by mode, since a mode change costs two settling frames.
  row_t rows [12] = '{
    '{8'h6C, 16'h0010, 1'h1, 1'h0, 8'h04}, '{8'hBB, 16'h0123, 1'h1, 1'h0, 8'h04},
    '{8'hBC, 16'h0200, 1'h1, 1'h0, 8'h04}, '{8'hEB, 16'h083E, 1'h1, 1'h0, 8'h04},
    '{8'hEC, 16'h0005, 1'h1, 1'h0, 8'h03}, '{8'h6C, 16'h0900, 1'h1, 1'h0, 8'h02},
    '{8'h6C, 16'h0000, 1'h1, 1'h1, 8'h02}, '{8'hEB, 16'h0000, 1'h1, 1'h1, 8'h02},
    '{8'hEC, 16'h0000, 1'h1, 1'h1, 8'h02}, '{8'hBC, 16'h0040, 1'h1, 1'h1, 8'h03},
    '{8'hBB, 16'h0100, 1'h0, 1'h0, 8'h03}, '{8'hEC, 16'h0000, 1'h0, 1'h0, 8'h03}};
  nand_spi_if link ();
  nand_read_dev u_nand_read_dev (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .buf_mode_i(buf_mode_i),
    .wp_enable_i(wp_enable_i), .page_next_o(page_next_o), .link(link));
  nand_read_host u_nand_read_host (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_opcode_i(cmd_opcode_i),
    .cmd_col_i(cmd_col_i), .cmd_buf_mode_i(cmd_buf_mode_i), .cmd_len_i(cmd_len_i),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .link(link));
  nand_multi_io_fast_read_chk u_nand_multi_io_fast_read_chk (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .sclk(link.sclk), .cs_n(link.cs_n), .host_io_o(link.host_io_o),
    .host_io_oe(link.host_io_oe), .dev_io_o(link.dev_io_o), .dev_io_oe(link.dev_io_oe),
    .io(link.io));
  // Clock generation.
  initial begin
    sys_clk_i = 1'h0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // Counts page wrap pulses over the whole run.
  always @(negedge sys_clk_i) begin
    if (page_next_o === 1'h1)
      pages++;
  end
  // ****
  // Helpers.
  // ****
  function automatic logic [7:0] pat(input int a);
    pat = 8'(a) ^ 8'(a >> 5);
  endfunction : pat
  // A refused or floated byte reads all ones through the pull-up.
  function automatic logic [7:0] exp_b(input logic [7:0] op, input int col, input logic bm,
      input logic wp, input int i);
    if (wp && op != 8'hBB && op != 8'hBC)
      exp_b = 8'hFF;
    else if (!bm)
      exp_b = pat(i % nand_read_pkg::BUF_BYTES);
    else if (col + i > int'(nand_read_pkg::LAST_COL))
      exp_b = 8'hFF;
    else
      exp_b = pat(col + i);
  endfunction : exp_b
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check
  task automatic wrap_up;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic wait_ready;
    int k;
    k = 0;
    while (cmd_ready_o !== 1'h1) begin
      @(negedge sys_clk_i);
      k++;
      if (k > 100) begin
        errors++;
        wrap_up();
      end
    end
  endtask : wait_ready
  // One read; with a stall the FIFO fills and the link clock must pause.
  task automatic go(input logic [7:0] op, input int col, input logic bm, input int n,
      input logic chk, input int stall);
    int got;
    int lim;
    got = 0;
    lim = 0;
    wait_ready();
    cmd_opcode_i = op;
    cmd_col_i = 16'(col);
    cmd_buf_mode_i = bm;
    cmd_len_i = 16'(n);
    cmd_valid_i = 1'h1;
    rd_ready_i = (stall == 0);
    @(negedge sys_clk_i);
    cmd_valid_i = 1'h0;
    while (got < n) begin
      @(negedge sys_clk_i);
      lim++;
      if (lim == stall)
        rd_ready_i = 1'h1;
      if (lim > 40000 + stall) begin
        errors++;
        wrap_up();
      end else if (rd_valid_o === 1'h1 && rd_ready_i) begin
        if (chk)
          check(rd_data_o, exp_b(op, col, bm, wp_enable_i, got));
        got++;
      end
    end
    rd_ready_i = 1'h1;
    wait_ready();
  endtask : go
  // Mode inputs settle on the link clock, so two frames pass first.
  task automatic set_mode(input logic bm, input logic wp);
    buf_mode_i = bm;
    wp_enable_i = wp;
    go(8'hBB, 0, bm, 1, 1'h0, 0);
    go(8'hBB, 0, bm, 1, 1'h0, 0);
  endtask : set_mode
  // ****
  // Main sequence.
  // ****
  initial begin
    nrst_i = 1'h0;
    wr_en_i = 1'h0;
    wr_addr_i = 12'h000;
    wr_data_i = 8'h00;
    buf_mode_i = 1'h1;
    wp_enable_i = 1'h0;
    cmd_valid_i = 1'h0;
    cmd_opcode_i = 8'h00;
    cmd_col_i = 16'h0000;
    cmd_buf_mode_i = 1'h0;
    cmd_len_i = 16'h0000;
    rd_ready_i = 1'h1;
    errors = 0;
    cmp_count = 0;
    pages = 0;
    repeat (3) @(negedge sys_clk_i);
    check(8'(link.cs_n), 8'h01);
    check(8'(link.dev_io_oe), 8'h00);
    check(8'(rd_valid_o), 8'h00);
    nrst_i = 1'h1;
    for (int a = 0; a < nand_read_pkg::BUF_BYTES; a++) begin
      @(negedge sys_clk_i);
      wr_en_i = 1'h1;
      wr_addr_i = 12'(a);
      wr_data_i = pat(a);
    end
    @(negedge sys_clk_i);
    wr_en_i = 1'h0;
    foreach (rows[r]) begin
      if (r == 0 || rows[r].bm !== buf_mode_i || rows[r].wp !== wp_enable_i)
        set_mode(rows[r].bm, rows[r].wp);
      go(rows[r].op, int'(rows[r].col), rows[r].bm, int'(rows[r].n), 1'h1, 0);
    end
    go(8'hEB, 0, 1'h0, nand_read_pkg::BUF_BYTES + 3, 1'h1, 2000);
    check(8'(pages), 8'h01);
    // reset cut in the data phase.
    cmd_valid_i = 1'h1;
    @(negedge sys_clk_i);
    cmd_valid_i = 1'h0;
    repeat (140) @(negedge sys_clk_i);
    check(8'(link.dev_io_oe), 8'h0F);
    nrst_i = 1'h0;
    @(negedge sys_clk_i);
    check(8'(link.cs_n), 8'h01);
    check(8'(link.dev_io_oe), 8'h00);
    check(8'({cmd_ready_o, rd_valid_o}), 8'h02);
    nrst_i = 1'h1;
    go(8'hEB, 0, 1'h0, 2, 1'h1, 0);
    wrap_up();
  end
endmodule : nand_multi_io_fast_read_tb
`default_nettype wire
